// ### scsp_pkg.sv
// constants, field layouts and carrier types of the switch control port
// assumes a single 250 MHz core clock; all pins but the fault and sense inputs are synchronised in the core
package scsp_pkg;
	localparam int FRAME_BITS = 16;
	localparam int CNT_W = 5;
	localparam int KA_BIT = 15;
	localparam int ADDR_HI = 12;
	localparam int ADDR_LO = 9;
	localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
	localparam int RD_SEL_W = 3;

	// timing
	localparam int CLK_MHZ = 250;
	localparam int KHZ_PER_MHZ = 1000;
	localparam int US_PER_MS = 1000;
	localparam int SLEEP_TIME_MS = 250;
	localparam int WDT_TIME_MS = 310;
	localparam int CLKMON_SLOW_KHZ = 7;
	localparam int CLKMON_FAST_KHZ = 730;
	localparam int SLEEP_CYC = SLEEP_TIME_MS * US_PER_MS * CLK_MHZ;
	localparam int WDT_CYC = WDT_TIME_MS * US_PER_MS * CLK_MHZ;
	localparam int CLKMON_SLOW_CYC = CLK_MHZ * KHZ_PER_MHZ / CLKMON_SLOW_KHZ;
	localparam int CLKMON_FAST_CYC = CLK_MHZ * KHZ_PER_MHZ / CLKMON_FAST_KHZ;

	// input register addresses
	localparam logic [ADDR_W-1:0] ADDR_RSEL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_GCR = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_CFG_A = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_CFG_B = 4'h3;

	// readable register indices
	localparam logic [RD_SEL_W-1:0] RD_STATUS = 3'h0;
	localparam logic [RD_SEL_W-1:0] RD_FAULT_A = 3'h1;
	localparam logic [RD_SEL_W-1:0] RD_FAULT_B = 3'h2;
	localparam logic [RD_SEL_W-1:0] RD_DIAG_A = 3'h3;
	localparam logic [RD_SEL_W-1:0] RD_DIAG_B = 3'h4;
	localparam logic [RD_SEL_W-1:0] RD_GCR = 3'h5;
	localparam logic [RD_SEL_W-1:0] RD_CFG_A = 3'h6;
	localparam logic [RD_SEL_W-1:0] RD_CFG_B = 3'h7;

	typedef struct packed {
		logic keepalive_disable;
		logic sense_select_hi;
		logic sense_select_lo;
	} scsp_gcr_type;

	typedef struct packed {
		logic direct_disable;
		logic ext_clock_sel;
		logic serial_on;
	} scsp_cfg_type;

	typedef struct packed {
		logic overcurrent_fault;
		logic overtemp_fault;
		logic supply_tied_fault;
		logic severe_short_fault;
	} scsp_chan_fault_type;

	typedef struct packed {
		logic open_load_while_active;
		logic open_load_while_idle;
	} scsp_diag_type;

	typedef struct packed {
		logic supply_high_fault;
		logic supply_low_fault;
		scsp_chan_fault_type [1:0] chan;
		scsp_diag_type [1:0] diag;
	} scsp_fault_type;

	typedef enum logic [1:0] {
		MODE_SLEEP = 2'b00,
		MODE_NORMAL = 2'b01,
		MODE_FAILSAFE = 2'b10
	} scsp_mode_type;

	typedef enum logic [1:0] {
		SENSE_OFF = 2'b00,
		SENSE_CH0 = 2'b01,
		SENSE_CH1 = 2'b10,
		SENSE_TEMP = 2'b11
	} scsp_sense_type;
endpackage

// ### scsp_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a bundle of asynchronous pins
// assumes each bit is an independent level; no bus coherency is implied
module scsp_sync
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1;

	// stage1 feeds only the second flop, never any logic
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			stage1 <= RESET_VAL;
			o_sync <= RESET_VAL;
		end
		else
		begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule

// ### scsp_regfile.sv
`timescale 1ns/1ps
// small word store for written input registers, registered read port
// assumes one write per cycle at most; clear is synchronous and wins
module scsp_regfile
#(
	parameter int DATA_W = 16,
	parameter int ADDR_W = 4
)
(
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_clear,
	input wire logic i_wr_en,
	input wire logic [ADDR_W-1:0] i_wr_addr,
	input wire logic [DATA_W-1:0] i_wr_data,
	input wire logic [ADDR_W-1:0] i_rd_addr,
	output logic [DATA_W-1:0] o_rd_data
);
	localparam int DEPTH = 1 << ADDR_W;
	logic [DATA_W-1:0] mem [DEPTH];
	logic [DATA_W-1:0] next_mem [DEPTH];
	logic [DATA_W-1:0] next_rd_data;

	// write and clear
	always_comb
	begin
		for (int i = 0; i < DEPTH; i++)
		begin
			if (i_clear)
				next_mem[i] = '0;
			else if (i_wr_en && i_wr_addr == ADDR_W'(i))
				next_mem[i] = i_wr_data;
			else
				next_mem[i] = mem[i];
		end
		next_rd_data = i_clear ? '0 : mem[i_rd_addr];
	end

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= '0;
			o_rd_data <= '0;
		end
		else
		begin
			mem <= next_mem;
			o_rd_data <= next_rd_data;
		end
	end
endmodule

// ### scsp_core.sv
`timescale 1ns/1ps
// serial port, sleep/wake, keep-alive watchdog and fault logic of the switch
// assumes pins other than the fault and sense inputs are asynchronous; fault and sense inputs are on i_clock
module scsp_core
#(
	parameter int SLEEP_CYCLES = scsp_pkg::SLEEP_CYC,
	parameter int WDT_CYCLES = scsp_pkg::WDT_CYC,
	parameter int CLK_SLOW_CYCLES = scsp_pkg::CLKMON_SLOW_CYC
)
(
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_select_n,
	input wire logic i_sclk,
	input wire logic i_mosi,
	output logic o_miso,
	output logic o_miso_oe,
	input wire logic i_reset_n,
	input wire logic i_direct_ctrl_a,
	input wire logic i_direct_ctrl_b,
	input wire logic i_load_type_a,
	input wire logic i_load_type_b,
	input wire logic i_pwm_clock,
	input wire scsp_pkg::scsp_fault_type i_faults,
	input wire logic i_sense_valid,
	output logic o_fault_flag_n,
	output logic o_fault_flag_n_oe,
	output logic o_sync_n,
	output logic o_sync_n_oe,
	output scsp_pkg::scsp_sense_type o_sense_sel,
	output logic o_sense_oe,
	output logic [1:0] o_chan_on,
	output logic [1:0] o_motor_profile,
	output scsp_pkg::scsp_mode_type o_mode
);
	import scsp_pkg::*;

	localparam int IDLE_W = $clog2(SLEEP_CYCLES + 1);
	localparam int WD_W = $clog2(WDT_CYCLES + 1);
	localparam int MON_W = $clog2(CLK_SLOW_CYCLES + 1);
	localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(SLEEP_CYCLES - 1);
	localparam logic [WD_W-1:0] WD_LAST = WD_W'(WDT_CYCLES - 1);
	localparam logic [MON_W-1:0] MON_LAST = MON_W'(CLK_SLOW_CYCLES);
	localparam logic [MON_W-1:0] MON_FAST = MON_W'(CLKMON_FAST_CYC);
	localparam logic [CNT_W-1:0] CNT_FRAME = CNT_W'(FRAME_BITS);
	localparam logic [CNT_W-1:0] CNT_MAX = '1;
	localparam int GCR_W = $bits(scsp_gcr_type);
	localparam int CFG_W = $bits(scsp_cfg_type);
	localparam logic [8:0] SYNC_RST = 9'h100; // select_n idles high

	// synchronised pins and their previous values
	logic sel_n, sclk, mosi, rst_n, pwm_clk;
	logic [1:0] dir, load_type;
	logic prev_sel_n, prev_sclk, prev_rst_n, prev_pwm;
	logic [1:0] prev_dir;

	scsp_sync #(
		.WIDTH(9),
		.RESET_VAL(SYNC_RST)
	) u_sync (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_async({i_select_n, i_sclk, i_mosi, i_reset_n, i_direct_ctrl_b,
			i_direct_ctrl_a, i_load_type_b, i_load_type_a, i_pwm_clock}),
		.o_sync({sel_n, sclk, mosi, rst_n, dir, load_type, pwm_clk})
	);

	// edge history
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			prev_sel_n <= 1'b1;
			prev_sclk <= 1'b0;
			prev_rst_n <= 1'b0;
			prev_pwm <= 1'b0;
			prev_dir <= '0;
		end
		else
		begin
			prev_sel_n <= sel_n;
			prev_sclk <= sclk;
			prev_rst_n <= rst_n;
			prev_pwm <= pwm_clk;
			prev_dir <= dir;
		end
	end

	logic active, sel_fall, sel_rise, sclk_rise, sclk_fall;
	logic rst_rise, pwm_rise;
	logic [1:0] dir_rise;

	// shift clock edges count only inside a frame
	assign active = ~sel_n;
	assign sel_fall = prev_sel_n & ~sel_n;
	assign sel_rise = ~prev_sel_n & sel_n;
	assign sclk_rise = active & ~prev_sclk & sclk;
	assign sclk_fall = active & prev_sclk & ~sclk;
	assign rst_rise = ~prev_rst_n & rst_n;
	assign pwm_rise = ~prev_pwm & pwm_clk;
	assign dir_rise = ~prev_dir & dir;

	// serial shifter: one register both receives and transmits, so a
	// chained device sees our input word after sixteen clocks
	logic [FRAME_BITS-1:0] shift, next_shift, rd_word;
	logic [CNT_W-1:0] bit_cnt, next_bit_cnt;
	logic miso, next_miso;

	always_comb
	begin
		next_shift = shift;
		next_bit_cnt = bit_cnt;
		next_miso = miso;
		if (sel_fall)
		begin
			next_shift = rd_word;
			next_bit_cnt = '0;
			next_miso = 1'b0;
		end
		else if (sclk_rise)
			next_miso = shift[FRAME_BITS-1];
		else if (sclk_fall)
		begin
			next_shift = {shift[FRAME_BITS-2:0], mosi};
			if (bit_cnt != CNT_MAX)
				next_bit_cnt = bit_cnt + 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			shift <= '0;
			bit_cnt <= '0;
			miso <= 1'b0;
		end
		else
		begin
			shift <= next_shift;
			bit_cnt <= next_bit_cnt;
			miso <= next_miso;
		end
	end

	assign o_miso = miso;
	assign o_miso_oe = active;

	// word latch: only a full 16-bit frame is taken; longer or shorter
	// frames are dropped so a glitchy select cannot corrupt settings
	logic word_done, ka_change;
	logic [ADDR_W-1:0] wr_addr;
	assign word_done = sel_rise & (bit_cnt == CNT_FRAME) & rst_n;
	assign wr_addr = shift[ADDR_HI:ADDR_LO];

	scsp_gcr_type global_config_reg, next_gcr;
	scsp_cfg_type [1:0] cfg, next_cfg;
	logic [RD_SEL_W-1:0] rd_sel, next_rd_sel;
	logic last_ka, next_last_ka;

	// input registers, held at reset values while reset_n is low
	always_comb
	begin
		next_gcr = global_config_reg;
		next_cfg = cfg;
		next_rd_sel = rd_sel;
		next_last_ka = last_ka;
		if (!rst_n)
		begin
			next_gcr = '0;
			next_cfg = '0;
			next_rd_sel = '0;
			next_last_ka = 1'b0;
		end
		else if (word_done)
		begin
			next_last_ka = shift[KA_BIT];
			if (wr_addr == ADDR_RSEL)
				next_rd_sel = shift[RD_SEL_W-1:0];
			if (wr_addr == ADDR_GCR)
				next_gcr = scsp_gcr_type'(shift[GCR_W-1:0]);
			if (wr_addr == ADDR_CFG_A)
				next_cfg[0] = scsp_cfg_type'(shift[CFG_W-1:0]);
			if (wr_addr == ADDR_CFG_B)
				next_cfg[1] = scsp_cfg_type'(shift[CFG_W-1:0]);
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			global_config_reg <= '0;
			cfg <= '0;
			rd_sel <= '0;
			last_ka <= 1'b0;
		end
		else
		begin
			global_config_reg <= next_gcr;
			cfg <= next_cfg;
			rd_sel <= next_rd_sel;
			last_ka <= next_last_ka;
		end
	end

	// full word store for readback of settings
	logic [ADDR_W-1:0] mem_rd_addr;
	logic [FRAME_BITS-1:0] mem_rd;

	always_comb
	begin
		unique case (rd_sel)
			RD_CFG_A: mem_rd_addr = ADDR_CFG_A;
			RD_CFG_B: mem_rd_addr = ADDR_CFG_B;
			default: mem_rd_addr = ADDR_GCR;
		endcase
	end

	scsp_regfile #(
		.DATA_W(FRAME_BITS),
		.ADDR_W(ADDR_W)
	) u_regfile (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_clear(~rst_n),
		.i_wr_en(word_done),
		.i_wr_addr(wr_addr),
		.i_wr_data(shift),
		.i_rd_addr(mem_rd_addr),
		.o_rd_data(mem_rd)
	);

	// mode, sleep timer and keep-alive watchdog
	scsp_mode_type mode, next_mode;
	logic [IDLE_W-1:0] idle_cnt, next_idle_cnt;
	logic [WD_W-1:0] wd_cnt, next_wd_cnt;
	logic wd_run, next_wd_run;
	logic sleep_due, wd_expired;

	assign ka_change = word_done & (shift[KA_BIT] != last_ka);
	assign sleep_due = ~rst_n & ~|dir & (idle_cnt == IDLE_LAST);
	assign wd_expired = wd_run & ~global_config_reg.keepalive_disable &
		(wd_cnt == WD_LAST);

	always_comb
	begin
		next_mode = mode;
		next_idle_cnt = idle_cnt;
		next_wd_cnt = wd_cnt;
		next_wd_run = wd_run;
		// idle time counts from the last falling edge of reset_n or a direct input
		if (rst_n || |dir)
			next_idle_cnt = '0;
		else if (idle_cnt != IDLE_LAST)
			next_idle_cnt = idle_cnt + 1'b1;
		if (rst_rise)
		begin
			next_wd_run = 1'b1;
			next_wd_cnt = '0;
		end
		else if (!rst_n)
		begin
			next_wd_run = 1'b0;
			next_wd_cnt = '0;
		end
		else if (ka_change)
			next_wd_cnt = '0;
		else if (wd_run && !global_config_reg.keepalive_disable &&
			mode == MODE_NORMAL && wd_cnt != WD_LAST)
			next_wd_cnt = wd_cnt + 1'b1;
		unique case (mode)
			MODE_SLEEP:
				if (rst_rise || |dir_rise)
					next_mode = MODE_NORMAL;
			MODE_NORMAL:
				if (sleep_due)
					next_mode = MODE_SLEEP;
				else if (wd_expired)
					next_mode = MODE_FAILSAFE;
			MODE_FAILSAFE:
				if (sleep_due)
					next_mode = MODE_SLEEP;
				else if (!rst_n)
					next_mode = MODE_NORMAL;
			default:
				next_mode = MODE_SLEEP;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			mode <= MODE_SLEEP;
			idle_cnt <= '0;
			wd_cnt <= '0;
			wd_run <= 1'b0;
		end
		else
		begin
			mode <= next_mode;
			idle_cnt <= next_idle_cnt;
			wd_cnt <= next_wd_cnt;
			wd_run <= next_wd_run;
		end
	end

	assign o_mode = mode;

	// pwm time-base monitor: too slow or too fast flags a clock failure;
	// only checked while a channel actually selects the external clock
	logic [MON_W-1:0] mon_cnt, next_mon_cnt;
	logic clk_fail, next_clk_fail, ext_used;
	assign ext_used = cfg[0].ext_clock_sel | cfg[1].ext_clock_sel;

	always_comb
	begin
		next_mon_cnt = mon_cnt;
		next_clk_fail = clk_fail;
		if (!ext_used)
		begin
			// start at the fast limit: the partial first period after
			// selecting the clock must not read as too fast
			next_mon_cnt = MON_FAST;
			next_clk_fail = 1'b0;
		end
		else if (pwm_rise)
		begin
			next_clk_fail = mon_cnt < MON_FAST;
			next_mon_cnt = '0;
		end
		else if (mon_cnt != MON_LAST)
			next_mon_cnt = mon_cnt + 1'b1;
		else
			next_clk_fail = 1'b1;
	end

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			mon_cnt <= '0;
			clk_fail <= 1'b0;
		end
		else
		begin
			mon_cnt <= next_mon_cnt;
			clk_fail <= next_clk_fail;
		end
	end

	// sticky faults: a new event beats a read clear in the same cycle
	scsp_fault_type sticky, next_sticky, clr_mask;
	logic clk_fail_st, next_clk_fail_st, clr_clk;

	always_comb
	begin
		clr_mask = '0;
		clr_clk = 1'b0;
		if (sel_fall)
		begin
			unique case (rd_sel)
				RD_STATUS:
				begin
					clr_mask.supply_high_fault = 1'b1;
					clr_mask.supply_low_fault = 1'b1;
					clr_clk = 1'b1;
				end
				RD_FAULT_A: clr_mask.chan[0] = '1;
				RD_FAULT_B: clr_mask.chan[1] = '1;
				RD_DIAG_A: clr_mask.diag[0] = '1;
				RD_DIAG_B: clr_mask.diag[1] = '1;
				RD_GCR, RD_CFG_A, RD_CFG_B: clr_clk = 1'b0;
			endcase
		end
		if (!rst_n)
		begin
			next_sticky = '0;
			next_clk_fail_st = 1'b0;
		end
		else
		begin
			next_sticky = (sticky & ~clr_mask) | i_faults;
			next_clk_fail_st = (clk_fail_st & ~clr_clk) | clk_fail;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			sticky <= '0;
			clk_fail_st <= 1'b0;
		end
		else
		begin
			sticky <= next_sticky;
			clk_fail_st <= next_clk_fail_st;
		end
	end

	assign o_fault_flag_n = 1'b0;
	assign o_fault_flag_n_oe = |sticky | clk_fail_st;

	// readable register mux, sampled into the shifter at select falling
	always_comb
	begin
		unique case (rd_sel)
			RD_STATUS: rd_word = FRAME_BITS'({mode, clk_fail_st,
				sticky.supply_high_fault, sticky.supply_low_fault,
				o_chan_on});
			RD_FAULT_A: rd_word = FRAME_BITS'(sticky.chan[0]);
			RD_FAULT_B: rd_word = FRAME_BITS'(sticky.chan[1]);
			RD_DIAG_A: rd_word = FRAME_BITS'(sticky.diag[0]);
			RD_DIAG_B: rd_word = FRAME_BITS'(sticky.diag[1]);
			RD_GCR, RD_CFG_A, RD_CFG_B: rd_word = mem_rd;
		endcase
	end

	// channel drive and sense-ready; fail-safe falls back to direct inputs
	logic [1:0] chan_on, next_chan_on;
	logic sync_low, next_sync_low;

	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			unique case (mode)
				MODE_NORMAL: next_chan_on[c] =
					(dir[c] & ~cfg[c].direct_disable) |
					(cfg[c].serial_on &
					~(cfg[c].ext_clock_sel & clk_fail));
				MODE_FAILSAFE: next_chan_on[c] = dir[c];
				default: next_chan_on[c] = 1'b0;
			endcase
		end
		next_sync_low = sync_low;
		if (|(chan_on & ~next_chan_on))
			next_sync_low = 1'b0;
		else if (i_sense_valid && o_sense_oe)
			next_sync_low = 1'b1;
	end

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			chan_on <= '0;
			sync_low <= 1'b0;
		end
		else
		begin
			chan_on <= next_chan_on;
			sync_low <= next_sync_low;
		end
	end

	assign o_chan_on = chan_on;
	assign o_sync_n = 1'b0;
	assign o_sync_n_oe = sync_low;
	assign o_sense_sel = scsp_sense_type'({global_config_reg.sense_select_hi,
		global_config_reg.sense_select_lo});
	assign o_sense_oe = global_config_reg.sense_select_hi | global_config_reg.sense_select_lo;
	assign o_motor_profile = load_type;
endmodule

// ### scsp_properties.sv
`timescale 1ns/1ps
// concurrent checks on the pins of the switch control port core
// assumes one core clock domain; bound to every core instance
module scsp_properties
import scsp_pkg::*;
#(
	parameter int SLEEP_CYCLES = scsp_pkg::SLEEP_CYC
)
(
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_select_n,
	input wire logic i_sclk,
	input wire logic o_miso,
	input wire logic o_miso_oe,
	input wire logic i_reset_n,
	input wire logic i_direct_ctrl_a,
	input wire logic i_direct_ctrl_b,
	input wire logic i_load_type_a,
	input wire logic i_load_type_b,
	input wire scsp_pkg::scsp_fault_type i_faults,
	input wire logic o_fault_flag_n_oe,
	input wire logic o_sync_n_oe,
	input wire scsp_pkg::scsp_sense_type o_sense_sel,
	input wire logic o_sense_oe,
	input wire logic [1:0] o_chan_on,
	input wire logic [1:0] o_motor_profile,
	input wire scsp_pkg::scsp_mode_type o_mode
);
	int idle;
	int next_idle;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	// idle time at the pins; the margin covers pin synchronisers
	always_comb
	begin
		next_idle = 0;
		if (!i_reset_n && !i_direct_ctrl_a && !i_direct_ctrl_b)
			next_idle = idle + int'(idle < SLEEP_CYCLES + 8);
	end
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
			idle <= 0;
		else
			idle <= next_idle;
	end
	sequence s_open;
		$fell(i_select_n);
	endsequence
	sequence s_shut;
		$rose(i_select_n);
	endsequence
	a_driver_on: assert property (s_open |-> ##[1:4] o_miso_oe)
		else $error("driver not enabled in frame");
	a_driver_off: assert property (s_shut |-> ##[1:4] !o_miso_oe)
		else $error("driver left on after frame");
	a_idle_quiet: assert property ((i_select_n && !i_sclk)[*6]
		|-> $stable(o_miso) && !o_miso_oe)
		else $error("data out moved while idle");
	a_sleep_time: assert property (idle == SLEEP_CYCLES + 8
		|-> o_mode == MODE_SLEEP)
		else $error("no sleep after idle time");
	a_wake_direct: assert property (o_mode == MODE_SLEEP &&
		($rose(i_direct_ctrl_a) || $rose(i_direct_ctrl_b))
		|-> ##[1:6] o_mode == MODE_NORMAL)
		else $error("no wake on direct input");
	a_wake_reset: assert property (o_mode == MODE_SLEEP &&
		$rose(i_reset_n) |-> ##[1:6] o_mode == MODE_NORMAL)
		else $error("no wake on reset pin");
	a_safe_direct: assert property ((o_mode == MODE_FAILSAFE &&
		$stable({i_direct_ctrl_b, i_direct_ctrl_a}))[*6]
		|-> o_chan_on == {i_direct_ctrl_b, i_direct_ctrl_a})
		else $error("channels not following direct inputs");
	a_load_type: assert property ($stable({i_load_type_b,
		i_load_type_a})[*5]
		|-> o_motor_profile == {i_load_type_b, i_load_type_a})
		else $error("profile not following load type");
	a_fault_flag: assert property ((i_reset_n[*4] ##0 (|i_faults))
		|-> ##[1:3] o_fault_flag_n_oe)
		else $error("fault flag not pulled low");
	a_sense_tri: assert property (o_sense_oe ==
		(o_sense_sel != SENSE_OFF))
		else $error("sense enable disagrees with select");
	a_sense_reset: assert property ((!i_reset_n)[*5]
		|-> !o_sense_oe && o_sense_sel == SENSE_OFF)
		else $error("sense left selected in reset");
	a_sync_off: assert property (|($past(o_chan_on) & ~o_chan_on)
		|-> !o_sync_n_oe)
		else $error("sense ready not released at turn-off");
endmodule
bind scsp_core scsp_properties #(.SLEEP_CYCLES(SLEEP_CYCLES)) u_props
(
	.i_clock, .i_arst_n, .i_select_n, .i_sclk, .o_miso, .o_miso_oe,
	.i_reset_n, .i_direct_ctrl_a, .i_direct_ctrl_b, .i_load_type_a,
	.i_load_type_b, .i_faults, .o_fault_flag_n_oe, .o_sync_n_oe,
	.o_sense_sel, .o_sense_oe, .o_chan_on, .o_motor_profile, .o_mode
);

// ### scsp_master.sv
`timescale 1ns/1ps
// serial master model that drives the link pins of the core
// assumes i_go is a one-cycle request; o_done rises once a frame ends
module scsp_master
(
	input wire logic i_clock,
	input wire logic i_go,
	input wire logic [15:0] i_word,
	input wire logic [4:0] i_bits,
	input wire logic i_miso,
	output logic o_select_n,
	output logic o_sclk,
	output logic o_mosi,
	output logic o_done,
	output logic [15:0] o_rx
);
	localparam int HALF = 20; // 160 ns link period at the core clock
	// one frame per request; idle data shows the inverse of its last bit
	initial
	begin
		o_select_n = 1'b1;
		o_sclk = 1'b0;
		o_mosi = 1'b0;
		o_done = 1'b0;
		o_rx = 16'h0000;
		forever
		begin
			@(posedge i_clock);
			if (i_go)
			begin
				o_done <= 1'b0;
				o_select_n <= 1'b0;
				repeat (HALF) @(posedge i_clock);
				for (int i = 0; i < i_bits; i++)
				begin
					o_sclk <= 1'b1;
					o_mosi <= i_word[15 - i];
					repeat (HALF) @(posedge i_clock);
					o_rx <= {o_rx[14:0], i_miso};
					o_sclk <= 1'b0;
					repeat (HALF) @(posedge i_clock);
				end
				o_select_n <= 1'b1; // clock is low here
				o_mosi <= ~o_mosi;
				repeat (HALF) @(posedge i_clock);
				o_done <= 1'b1;
			end
		end
	end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the switch control port core
// assumes the master model owns the link pins; long times are shortened
module tb_top;
	import scsp_pkg::*;
	localparam int SLP = 500;
	localparam int WDT = 3000;
	logic clk, arst_n, go, rst_pin, da, db, la, lb, pwm, sv, ka, pwm_hold;
	logic sel_n, sclk, mosi, miso, miso_oe, done, flag_oe, sync_oe, s_oe;
	logic [15:0] word, rx, keep;
	logic [4:0] nbits;
	logic [1:0] chan, motor;
	scsp_fault_type flt;
	scsp_sense_type ssel;
	scsp_mode_type mode;
	int failures, total_checks;
	scsp_master u_master (.i_clock(clk), .i_go(go), .i_word(word),
		.i_bits(nbits), .i_miso(miso), .o_select_n(sel_n), .o_sclk(sclk),
		.o_mosi(mosi), .o_done(done), .o_rx(rx));
	scsp_core #(.SLEEP_CYCLES(SLP), .WDT_CYCLES(WDT),
		.CLK_SLOW_CYCLES(1000)) dut (.i_clock(clk), .i_arst_n(arst_n),
		.i_select_n(sel_n), .i_sclk(sclk), .i_mosi(mosi), .o_miso(miso),
		.o_miso_oe(miso_oe), .i_reset_n(rst_pin), .i_direct_ctrl_a(da),
		.i_direct_ctrl_b(db), .i_load_type_a(la), .i_load_type_b(lb),
		.i_pwm_clock(pwm), .i_faults(flt), .i_sense_valid(sv),
		.o_fault_flag_n(), .o_fault_flag_n_oe(flag_oe), .o_sync_n(),
		.o_sync_n_oe(sync_oe), .o_sense_sel(ssel), .o_sense_oe(s_oe),
		.o_chan_on(chan), .o_motor_profile(motor), .o_mode(mode));
	// core clock and a free pwm time base inside the monitor's window
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always
	begin
		repeat (300) @(posedge clk);
		if (!pwm_hold)
			pwm <= ~pwm;
	end
	task check(string name, logic [15:0] seen, logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one frame; the keep-alive bit alternates only on whole words
	task send(logic [3:0] a, logic [8:0] d, int n);
		int k;
		if (n == 16)
			ka = ~ka; // master alternates the keep-alive bit
		word <= {ka, 2'b00, a, d};
		nbits <= n[4:0];
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		k = 0;
		while (done !== 1'b1 && k < 2000)
		begin
			@(posedge clk);
			k++;
		end
		check("frame done", 16'(done), 16'h0001);
		repeat (6) @(posedge clk);
	endtask
	task t_serial;
		rst_pin <= 1'b1;
		repeat (10) @(posedge clk);
		check("wake", 16'(mode), 16'(MODE_NORMAL));
		for (int k = 0; k < 4; k++)
		begin
			send(ADDR_GCR, 9'(k), 16);
			keep = word;
			check("sense sel", 16'(ssel), 16'(k));
			check("sense oe", 16'(s_oe), 16'(k != 0));
		end
		send(ADDR_RSEL, 9'(RD_GCR), 16);
		send(ADDR_GCR, 9'h000, 15);
		check("short frame", 16'(ssel), 16'(SENSE_TEMP));
		send(ADDR_RSEL, 9'(RD_GCR), 16);
		check("readback", rx, keep);
		$display("serial test done");
	endtask
	task t_watchdog;
		repeat (1000) @(posedge clk);
		check("alive", 16'(mode), 16'(MODE_NORMAL));
		repeat (WDT) @(posedge clk);
		check("timeout", 16'(mode), 16'(MODE_FAILSAFE));
		da <= 1'b1;
		repeat (8) @(posedge clk);
		check("safe chan", 16'(chan), 16'h0001);
		da <= 1'b0;
		$display("watchdog test done");
	endtask
	task t_sleep;
		rst_pin <= 1'b0;
		repeat (8) @(posedge clk);
		check("cleared", 16'(ssel), 16'(SENSE_OFF));
		repeat (SLP - 100) @(posedge clk);
		check("not yet", 16'(mode), 16'(MODE_NORMAL));
		repeat (200) @(posedge clk);
		check("asleep", 16'(mode), 16'(MODE_SLEEP));
		db <= 1'b1;
		la <= 1'b0;
		repeat (8) @(posedge clk);
		check("woken", 16'(mode), 16'(MODE_NORMAL));
		check("chan b", 16'(chan), 16'h0002);
		check("profile", 16'(motor), 16'h0002);
		db <= 1'b0;
		$display("sleep test done");
	endtask
	task t_fault;
		rst_pin <= 1'b1;
		// a fault seen once the synced reset is high is held until read
		repeat (4) @(posedge clk);
		flt.chan[0].overcurrent_fault <= 1'b1;
		@(posedge clk);
		flt <= '0;
		repeat (4) @(posedge clk);
		check("flag", 16'(flag_oe), 16'h0001);
		send(ADDR_RSEL, 9'(RD_FAULT_A), 16);
		send(ADDR_RSEL, 9'(RD_FAULT_A), 16);
		check("fault bit", 16'(rx[3]), 16'h0001);
		send(ADDR_RSEL, 9'(RD_FAULT_A), 16);
		check("read clears", 16'(rx[3]), 16'h0000);
		check("flag off", 16'(flag_oe), 16'h0000);
		$display("fault test done");
	endtask
	// serial-on channel on the external time base, sense-ready, clock loss
	task t_clock;
		send(ADDR_CFG_A, 9'h003, 16);
		send(ADDR_GCR, 9'h001, 16);
		check("serial on", 16'(chan), 16'h0001);
		sv <= 1'b1;
		@(posedge clk);
		sv <= 1'b0;
		@(posedge clk);
		check("sense ready", 16'(sync_oe), 16'h0001);
		pwm_hold <= 1'b1;
		repeat (1800) @(posedge clk);
		check("clock fail", 16'(chan), 16'h0000);
		check("turn-off", 16'(sync_oe), 16'h0000);
		check("fail flag", 16'(flag_oe), 16'h0001);
		pwm_hold <= 1'b0;
		$display("clock test done");
	endtask
	task results;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// a hang is cut short well beyond the expected run time
	initial
	begin
		#200000;
		failures++;
		$display("run limit reached");
		results;
	end
	initial
	begin
		arst_n = 1'b0;
		{go, rst_pin, da, db, pwm, sv, ka, pwm_hold} = '0;
		{la, lb} = 2'b11;
		flt = '0;
		word = 16'h0000;
		keep = 16'h0000;
		nbits = 5'h10;
		failures = 0;
		total_checks = 0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_serial;
		t_watchdog;
		t_sleep;
		t_fault;
		t_clock;
		results;
	end
endmodule
